// ==== core/srs_spi_slave.sv ====
// Serial register access slave: frame shifting, command latch and status byte
//
// Operation
// - Forty bit frame, address then data, MSB first
// - Bit 39 high means write
// - Always thirty-two data bits per access
// - After read, return previously addressed register
// - After write, echo previous write data
// - Read leaves register unchanged, data ignored
// - Data returned in every frame
// - Top byte returned is status byte
// - Status captured at access end, sent next
// - Bit7 zero, bits6/5 left limit switches
// - Bits4/3 target speed reached per motor
// - Bits2/1 driver faults, cleared by reading
// - Bit0 reset flag, cleared by reading
// - Values right aligned, signed as two's complement
// - Sample on rising, shift on falling clock
// - Extra bits pass out forty clocks later
// - Chip select rise latches and executes command
// - Only last forty bits form the command
// - Clock idles high, mode three
// - Pulses under twenty nanoseconds ignored
`timescale 1ns/100ps
`default_nettype none
`include "srs_defs.svh"

module srs_spi_slave
  import srs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Serial bus pins
  input wire logic spi_csn_i,
  input wire logic spi_sck_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_n_o,
  // Motion and driver status from the controller core
  input wire logic stop_left_m1_i,
  input wire logic stop_left_m2_i,
  input wire logic speed_reached_m1_i,
  input wire logic speed_reached_m2_i,
  input wire logic [1:0] drv_fault_i,
  // Command towards the register bank
  output logic cmd_valid_o,
  output logic cmd_write_o,
  output logic [6:0] cmd_addr_o,
  output logic [31:0] cmd_data_o,
  input wire logic [31:0] rd_data_i,
  // Global status flags and frame diagnostics
  output logic [2:0] global_status_register_o,
  output logic abort_o,
  output logic chained_o
);

  // Filtered pin levels
  logic [`SRS_PINS-1:0] pin_f;
  logic csn_f;
  logic sck_f;
  logic sdi_f;

  // Edge detection on the filtered levels
  logic csn_d_r;
  logic sck_d_r;
  logic csn_fall;
  logic csn_rise;
  logic sck_rise;
  logic sck_fall;

  // Frame sequencer
  srs_state_t state_r;
  srs_state_t state_nxt;

  // Bit handling
  logic samp_r;
  logic pend_r;
  logic [`SRS_CNT_W-1:0] cnt_r;
  logic full_frame;
  logic [`SRS_FRAME_BITS-1:0] shreg;
  logic [`SRS_FRAME_BITS-1:0] last_bits;
  logic shift_en;
  logic load_en;

  // Command and reply state
  logic cmd_write_r;
  logic [6:0] cmd_addr_r;
  logic [31:0] cmd_data_r;
  logic [31:0] reply_r;
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [2:0] global_status_register_r;
  logic [2:0] global_status_register_clr;
  logic abort_r;
  logic chained_r;
  logic global_status_register_read;

  // All three bus inputs pass the synchroniser and glitch filter
  srs_pin_filter u_filter
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i({spi_sdi_i, spi_sck_i, spi_csn_i}),
    .pin_o(pin_f)
  );

  assign csn_f = pin_f[`SRS_PIN_CSN];
  assign sck_f = pin_f[`SRS_PIN_SCK];
  assign sdi_f = pin_f[`SRS_PIN_SDI];

  // Delayed copies for edge detection; idle levels are high
  // Resetting them to the idle level keeps a false edge from appearing
  // on the first cycle after reset, before the filter has settled
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      csn_d_r <= 1'b1;
      sck_d_r <= 1'b1;
    end
    else
    begin
      csn_d_r <= csn_f;
      sck_d_r <= sck_f;
    end
  end

  // Clock edges only count inside a selected frame
  assign csn_fall = csn_d_r & ~csn_f;
  assign csn_rise = ~csn_d_r & csn_f;
  assign sck_rise = ~sck_d_r & sck_f & ~csn_f & (state_r == SRS_XFER);
  assign sck_fall = sck_d_r & ~sck_f & ~csn_f & (state_r == SRS_XFER);

  // Frame sequencer: wait, shift, then one execution cycle
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      SRS_IDLE:
      begin
        if (csn_fall)
          state_nxt = SRS_XFER;
      end
      SRS_XFER:
      begin
        if (csn_rise)
        begin
          if (full_frame)
            state_nxt = SRS_EXEC;
          else
            state_nxt = SRS_IDLE;
        end
      end
      SRS_EXEC:
      begin
        state_nxt = SRS_IDLE;
      end
      default:
      begin
        state_nxt = SRS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      state_r <= SRS_IDLE;
    else
      state_r <= state_nxt;
  end

  // Input bit is taken on the rising clock edge
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      samp_r <= 1'b0;
    else if (sck_rise)
      samp_r <= sdi_f;
  end

  // Marks a sampled bit not yet moved into the shift register
  // The first falling edge of a frame finds nothing pending, so the
  // status bit already on the output is not shifted away early
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      pend_r <= 1'b0;
    else if (load_en)
      pend_r <= 1'b0;
    else if (sck_rise)
      pend_r <= 1'b1;
    else if (sck_fall)
      pend_r <= 1'b0;
  end

  // Rising edge count, saturating at one frame length
  // Saturation keeps long chained frames from wrapping the count back
  // into the short-frame range and losing the command
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      cnt_r <= 6'h00;
    else if (load_en)
      cnt_r <= 6'h00;
    else if (sck_rise && !full_frame)
      cnt_r <= cnt_r + 6'h01;
  end

  assign full_frame = (cnt_r == `SRS_CNT_W'(`SRS_FRAME_BITS));

  // Reply is loaded at frame start; output moves on the falling edge
  assign load_en = (state_r == SRS_IDLE) && csn_fall;
  assign shift_en = sck_fall && pend_r;

  srs_shifter u_shift
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .load_i(load_en),
    .load_val_i({status_r, reply_r}),
    .shift_i(shift_en),
    .bit_i(samp_r),
    .shreg_o(shreg)
  );

  // Mode three ends on a rising edge, so the last bit may still be pending
  assign last_bits = pend_r ? {shreg[`SRS_FRAME_BITS-2:0], samp_r} : shreg;

  // Serial output is released whenever chip select is high
  assign spi_sdo_o = shreg[`SRS_FRAME_BITS-1];
  assign spi_sdo_oe_n_o = csn_f;

  // Command latch at the end of a complete frame
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cmd_write_r <= 1'b0;
      cmd_addr_r <= 7'h00;
      cmd_data_r <= 32'h0000_0000;
    end
    else if (state_r == SRS_XFER && csn_rise && full_frame)
    begin
      cmd_write_r <= last_bits[`SRS_WRITE_BIT];
      cmd_addr_r <= last_bits[`SRS_ADDR_MSB:`SRS_ADDR_LSB];
      cmd_data_r <= last_bits[`SRS_DATA_MSB:0];
    end
  end

  // A read also presents the latched data field; the bank must not store its data
  assign cmd_valid_o = (state_r == SRS_EXEC);
  assign cmd_write_o = cmd_write_r;
  assign cmd_addr_o = cmd_addr_r;
  assign cmd_data_o = cmd_data_r;

  assign global_status_register_read = (state_r == SRS_EXEC) && !cmd_write_r && (cmd_addr_r == `SRS_GLOBAL_STATUS_REGISTER_ADDR);

  // Reply data for the next frame: echo on write, register on read
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      reply_r <= 32'h0000_0000;
    else if (state_r == SRS_EXEC)
    begin
      if (cmd_write_r)
        reply_r <= cmd_data_r;
      else if (global_status_register_read)
        reply_r <= {29'h0000_0000, global_status_register_r};
      else
        reply_r <= rd_data_i;
    end
  end

  // Global flags: faults are sticky, reset flag set by reset; set beats clear
  // A fault arriving in the very cycle of a clearing read stays flagged,
  // so it can never be lost between two reads
  assign global_status_register_clr = global_status_register_read ? 3'h7 : 3'h0;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      global_status_register_r <= `SRS_GLOBAL_STATUS_REGISTER_RST;
    else
      global_status_register_r <= (global_status_register_r & ~global_status_register_clr) | {drv_fault_i, 1'b0};
  end

  assign global_status_register_o = global_status_register_r;

  // Status byte assembled from live inputs and the sticky flags
  always_comb
  begin
    status_nxt = 8'h00;
    status_nxt[`SRS_ST_RSVD] = 1'b0;
    status_nxt[`SRS_ST_STOP2] = stop_left_m2_i;
    status_nxt[`SRS_ST_STOP1] = stop_left_m1_i;
    status_nxt[`SRS_ST_VEL2] = speed_reached_m2_i;
    status_nxt[`SRS_ST_VEL1] = speed_reached_m1_i;
    status_nxt[`SRS_ST_ERR2] = global_status_register_r[2];
    status_nxt[`SRS_ST_ERR1] = global_status_register_r[1];
    status_nxt[`SRS_ST_RESET] = global_status_register_r[0];
  end

  // Snapshot at every frame end, aborted ones included
  // It takes the flags before a clearing read acts, so a cleared flag
  // leaves the status byte two frames after that read
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      status_r <= {5'h00, `SRS_GLOBAL_STATUS_REGISTER_RST};
    else if (state_r == SRS_XFER && csn_rise)
      status_r <= status_nxt;
  end

  // One cycle pulse when a short frame is dropped
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      abort_r <= 1'b0;
    else
      abort_r <= (state_r == SRS_XFER) && csn_rise && !full_frame;
  end

  assign abort_o = abort_r;

  // Set once a frame runs past forty bits, showing chained devices
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      chained_r <= 1'b0;
    else if (load_en)
      chained_r <= 1'b0;
    else if (sck_rise && full_frame)
      chained_r <= 1'b1;
  end

  assign chained_o = chained_r;

endmodule : srs_spi_slave
`default_nettype wire

// ==== core/srs_defs.svh ====
// Constants of the serial register access slave
`ifndef SRS_DEFS_SVH
`define SRS_DEFS_SVH

// Frame layout
`define SRS_FRAME_BITS 40
`define SRS_CNT_W 6
`define SRS_WRITE_BIT 39
`define SRS_ADDR_MSB 38
`define SRS_ADDR_LSB 32
`define SRS_DATA_MSB 31

// Status byte positions
`define SRS_ST_RSVD 7
`define SRS_ST_STOP2 6
`define SRS_ST_STOP1 5
`define SRS_ST_VEL2 4
`define SRS_ST_VEL1 3
`define SRS_ST_ERR2 2
`define SRS_ST_ERR1 1
`define SRS_ST_RESET 0

// Global status register address and its reset value
`define SRS_GLOBAL_STATUS_REGISTER_ADDR 7'h01
`define SRS_GLOBAL_STATUS_REGISTER_RST 3'h1

// Pin order inside the filter vector
`define SRS_PINS 3
`define SRS_PIN_CSN 0
`define SRS_PIN_SCK 1
`define SRS_PIN_SDI 2
`define SRS_PIN_IDLE 3'h7

// Glitch filter: least pulse width in ns, cycles rounded up
`define SRS_CLK_NS 5
`define SRS_FILT_NS 20
`define SRS_FILT_CYC ((`SRS_FILT_NS + `SRS_CLK_NS - 1) / `SRS_CLK_NS)
`define SRS_FILT_W 3

`endif

// ==== core/srs_pkg.sv ====
// Types of the serial register access slave
package srs_pkg;

  // Frame sequencer states
  typedef enum logic [1:0]
  {
    SRS_IDLE = 2'b00,
    SRS_XFER = 2'b01,
    SRS_EXEC = 2'b10
  } srs_state_t;

endpackage : srs_pkg

// ==== core/srs_pin_filter.sv ====
// Synchroniser and glitch filter for the serial bus pins
`timescale 1ns/100ps
`default_nettype none
`include "srs_defs.svh"

module srs_pin_filter
  import srs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [`SRS_PINS-1:0] pin_i,
  output var logic [`SRS_PINS-1:0] pin_o
);

  // Idle level of each pin, high for all three on a mode three bus
  localparam logic [`SRS_PINS-1:0] IDLE_LVL = `SRS_PIN_IDLE;

  genvar g;
  generate
    for (g = 0; g < `SRS_PINS; g++)
    begin : g_pin
      logic meta_r;
      logic sync_r;
      logic filt_r;
      logic [`SRS_FILT_W-1:0] cnt_r;

      // Two flops; meta_r feeds sync_r and nothing else
      always_ff @(posedge clk_i)
      begin
        if (!rst_n_i)
        begin
          meta_r <= IDLE_LVL[g];
          sync_r <= IDLE_LVL[g];
        end
        else
        begin
          meta_r <= pin_i[g];
          sync_r <= meta_r;
        end
      end

      // A new level must hold the full filter time before it is taken
      always_ff @(posedge clk_i)
      begin
        if (!rst_n_i)
        begin
          filt_r <= IDLE_LVL[g];
          cnt_r <= 3'h0;
        end
        else if (sync_r == filt_r)
          cnt_r <= 3'h0;
        else if (cnt_r == `SRS_FILT_W'(`SRS_FILT_CYC - 1))
        begin
          filt_r <= sync_r;
          cnt_r <= 3'h0;
        end
        else
          cnt_r <= cnt_r + 3'h1;
      end

      assign pin_o[g] = filt_r;
    end
  endgenerate

endmodule : srs_pin_filter
`default_nettype wire

// ==== core/srs_shifter.sv ====
// Forty bit frame shift register
`timescale 1ns/100ps
`default_nettype none
`include "srs_defs.svh"

module srs_shifter
  import srs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [`SRS_FRAME_BITS-1:0] load_val_i,
  input wire logic shift_i,
  input wire logic bit_i,
  output var logic [`SRS_FRAME_BITS-1:0] shreg_o
);

  logic [`SRS_FRAME_BITS-1:0] shreg_r;

  // Load wins over shift; both never coincide in practice
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      shreg_r <= 40'h00_0000_0000;
    else if (load_i)
      shreg_r <= load_val_i;
    else if (shift_i)
      shreg_r <= {shreg_r[`SRS_FRAME_BITS-2:0], bit_i};
  end

  assign shreg_o = shreg_r;

endmodule : srs_shifter
`default_nettype wire

// ==== bench/srs_spi_master.sv ====
// Bus master model for the serial link, clock idle high
`timescale 1ns/100ps
`default_nettype none

module srs_spi_master (
  input wire logic clk_i,
  input wire logic sdo_i,
  output var logic csn_o,
  output var logic sck_o,
  output var logic sdi_o
);
  // Deselected with the clock parked high
  initial
  begin
    csn_o = 1'b1;
    sck_o = 1'b1;
    sdi_o = 1'b0;
  end

  // Every pin change lands one step after a system clock edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wt

  // One frame of n bits, MSB first; 125 ns bit period keeps well under half the system clock
  task automatic xfer(input int n, input logic [47:0] tx, output logic [47:0] rx);
    rx = '0;
    csn_o = 1'b0;
    wt(12);
    for (int i = n - 1; i >= 0; i--)
    begin
      sck_o = 1'b0;
      sdi_o = tx[i];
      wt(12);
      rx = {rx[46:0], sdo_i};
      sck_o = 1'b1;
      wt(13);
    end
    csn_o = 1'b1;
    sdi_o = ~sdi_o; // Released line must not keep looking like data
    wt(12);
  endtask : xfer

  // Select pulse too short for the pin filter
  task automatic glitch;
    csn_o = 1'b0;
    wt(2);
    csn_o = 1'b1;
    wt(12);
  endtask : glitch
endmodule : srs_spi_master
`default_nettype wire

// ==== bench/srs_spi_slave_chk.sv ====
// Concurrent checks on the pins of the serial access slave
`timescale 1ns/100ps
`default_nettype none
`include "srs_defs.svh"

module srs_spi_slave_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic spi_csn_i,
  input wire logic spi_sck_i,
  input wire logic spi_sdi_i,
  input wire logic spi_sdo_o,
  input wire logic spi_sdo_oe_n_o,
  input wire logic [1:0] drv_fault_i,
  input wire logic cmd_valid_o,
  input wire logic cmd_write_o,
  input wire logic [6:0] cmd_addr_o,
  input wire logic [31:0] cmd_data_o,
  input wire logic [2:0] global_status_register_o,
  input wire logic abort_o
);
  logic [3:0] hi_r, lo_r, sck_r;

  // Saturating run lengths of raw pin levels, to step past the filter delay
  always_ff @(posedge clk_i)
  begin
    hi_r <= (!rst_n_i || !spi_csn_i) ? 4'h0 : hi_r + {3'h0, hi_r != 4'hF};
    lo_r <= (!rst_n_i || spi_csn_i) ? 4'h0 : lo_r + {3'h0, lo_r != 4'hF};
    sck_r <= (!rst_n_i || !spi_sck_i) ? 4'h0 : sck_r + {3'h0, sck_r != 4'hF};
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_oe_idle_high: assert property (hi_r > 4'hA |-> spi_sdo_oe_n_o)
    else $error("output driven while deselected");
  a_oe_frame_low: assert property (lo_r > 4'hA |-> !spi_sdo_oe_n_o)
    else $error("output released inside a frame");
  a_sdo_hold_high: assert property (sck_r > 4'h1 && lo_r > 4'hA |-> $stable(spi_sdo_o))
    else $error("output changed while bus clock high");
  a_first_bit_zero: assert property ($fell(spi_sdo_oe_n_o) |=> !spi_sdo_o)
    else $error("reserved status bit not zero");
  a_end_outcome: assert property ($rose(spi_sdo_oe_n_o) |-> ##[0:3] (cmd_valid_o || abort_o))
    else $error("frame end without command or abort");
  a_abort_no_exec: assert property (abort_o |-> !cmd_valid_o ##1 !abort_o && !cmd_valid_o)
    else $error("aborted frame executed");
  a_valid_single: assert property (cmd_valid_o |=> !cmd_valid_o [*8])
    else $error("command pulse repeated");
  a_cmd_hold: assert property ($changed({cmd_write_o, cmd_addr_o, cmd_data_o}) |-> cmd_valid_o)
    else $error("command fields moved without a command");
  a_fault_sets: assert property (|drv_fault_i |=> (global_status_register_o[2:1] & $past(drv_fault_i)) == $past(drv_fault_i))
    else $error("driver fault not flagged");
  a_global_status_register_reset: assert property (disable iff (1'b0) !rst_n_i |=> global_status_register_o == `SRS_GLOBAL_STATUS_REGISTER_RST && !cmd_valid_o)
    else $error("reset flag not set by reset");

  // Main scenarios reached
  c_write: cover property (cmd_valid_o && cmd_write_o);
  c_read: cover property (cmd_valid_o && !cmd_write_o);
  c_abort: cover property (abort_o);
endmodule : srs_spi_slave_chk

bind srs_spi_slave srs_spi_slave_chk i_chk (.clk_i, .rst_n_i, .spi_csn_i, .spi_sck_i, .spi_sdi_i, .spi_sdo_o,
  .spi_sdo_oe_n_o, .drv_fault_i, .cmd_valid_o, .cmd_write_o, .cmd_addr_o, .cmd_data_o, .global_status_register_o, .abort_o);
`default_nettype wire

// ==== bench/srs_spi_slave_tb_top.sv ====
// Testbench of the serial register access slave
`timescale 1ns/100ps
`default_nettype none
`include "srs_defs.svh"

module srs_spi_slave_tb_top;
  logic clk_i, rst_n_i, csn, sck, sdi, sdo, oe_n, stop1, stop2, vel1, vel2;
  logic cmd_valid, cmd_write, abort, chained;
  logic [1:0] fault;
  logic [2:0] global_status_register;
  logic [6:0] cmd_addr;
  logic [31:0] cmd_data, rd_data;
  logic [47:0] rx;
  int errors, checks_done, n_abort;

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Bank stand-in: a recognisable pattern per address; the global status reply must come from the slave itself
  function automatic logic [31:0] pb(input logic [6:0] a);
    return {25'h0A5A5A5, a};
  endfunction : pb
  assign rd_data = pb(cmd_addr);

  // Released output shows the inverse of its last bit, so a late output enable is caught
  srs_spi_master i_mst (.clk_i(clk_i), .sdo_i(oe_n ? ~sdo : sdo), .csn_o(csn), .sck_o(sck), .sdi_o(sdi));

  srs_spi_slave i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .spi_csn_i(csn), .spi_sck_i(sck), .spi_sdi_i(sdi),
    .spi_sdo_o(sdo), .spi_sdo_oe_n_o(oe_n), .stop_left_m1_i(stop1), .stop_left_m2_i(stop2),
    .speed_reached_m1_i(vel1), .speed_reached_m2_i(vel2), .drv_fault_i(fault), .cmd_valid_o(cmd_valid),
    .cmd_write_o(cmd_write), .cmd_addr_o(cmd_addr), .cmd_data_o(cmd_data), .rd_data_i(rd_data),
    .global_status_register_o(global_status_register), .abort_o(abort), .chained_o(chained));

  // Abort pulses seen, so short or filtered frames can be told apart
  always @(posedge clk_i)
    if (abort === 1'b1)
      n_abort++;

  task automatic chk(input logic [47:0] exp, input logic [47:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk

  task automatic fr(input int n, input logic [47:0] tx, input logic [47:0] exp);
    i_mst.xfer(n, tx, rx);
    chk(exp, rx);
  endtask : fr

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // Hang guard, about five times the expected run
  initial
  begin
    #200000;
    errors++;
    report_and_stop();
  end

  initial
  begin
    {rst_n_i, stop1, stop2, vel1, vel2, fault} = 7'h18;
    {errors, checks_done, n_abort} = '0;
    repeat (5) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    // Pipelined reads, write echo, status capture
    fr(40, 48'h22_0000_0000, {8'h01, 32'h0});
    fr(40, 48'hA7_00AB_CDEF, {8'h49, pb(7'h22)});
    chk({9'h1, 7'h27, 32'h00AB_CDEF}, {8'h0, cmd_write, cmd_addr, cmd_data});
    fr(40, 48'h01_FFFF_FFFF, {8'h49, 32'h00AB_CDEF});
    chk(48'h0, {44'h0, cmd_write, global_status_register});
    $display("test pipeline done");
    // Driver faults become sticky flags and reach the status byte
    fault = 2'b11;
    i_mst.wt(2);
    fault = 2'b00;
    fr(40, 48'h22_0000_0000, {8'h49, 32'h1});
    {stop2, stop1, vel2, vel1} = 4'h6;
    fr(40, 48'h22_0000_0000, {8'h4E, pb(7'h22)});
    $display("test status done");
    // Daisy chain, short frame and filtered glitch
    fr(48, {8'h5A, 40'hA3_1234_5678}, {8'h36, pb(7'h22), 8'h5A});
    chk({9'h1, 7'h23, 32'h1234_5678}, {8'h0, cmd_write, cmd_addr, cmd_data});
    chk(48'h1, {47'h0, chained});
    i_mst.xfer(20, 48'hF_FFFF, rx);
    chk(48'h1, n_abort);
    i_mst.glitch();
    chk(48'h1, n_abort);
    fr(40, 48'h05_0000_0000, {8'h36, 32'h1234_5678});
    chk({9'h0, 7'h05, 32'h0}, {8'h0, cmd_write, cmd_addr, 32'h0});
    $display("test chain done");
    report_and_stop();
  end
endmodule : srs_spi_slave_tb_top
`default_nettype wire
